/* File: pkg/dcf_pkg.sv */
// constants shared by the checksum feeder and its checksum unit
package dcf_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned REG_AW = 4;
  // register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_SRC = 4'h4;
  localparam logic [3:0] OFS_LEN = 4'h8;
  localparam logic [3:0] OFS_STAT = 4'hc;
  // control fields
  localparam int unsigned CTRL_EN = 0;
  localparam int unsigned CTRL_TCIE = 1;
  localparam int unsigned CTRL_STREAM = 2;
  localparam int unsigned CTRL_SIZE_LO = 3;
  localparam int unsigned CTRL_FIFO = 5;
  localparam int unsigned CTRL_W = 6;
  // status fields
  localparam int unsigned STAT_TC = 0;
  localparam int unsigned STAT_BUSY = 1;
  // element size codes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  // checksum defaults
  localparam logic [31:0] INIT_VALUE = 32'hffffffff;
  localparam logic [31:0] GEN_GENERATOR_POLYNOMIAL = 32'h04c11db7;
endpackage

/* File: rtl/dcf_checksum_unit.sv */
// checksum unit: one data register, accumulates over successive writes
`timescale 1ns/1ns
module dcf_checksum_unit #(
  parameter logic [31:0] GENERATOR_POLYNOMIAL = dcf_pkg::GEN_GENERATOR_POLYNOMIAL,
  parameter logic [31:0] INIT = dcf_pkg::INIT_VALUE
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // data register port
  input wire logic i_init,
  input wire logic i_wr,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_rdata
);
  typedef struct packed {
    logic [31:0] checksum_data_register;
  } dcf_cu_state_t;
  dcf_cu_state_t st, next_st;

  // full 32-bit step unrolled in one cycle so the feeder never waits
  function automatic logic [31:0] dcf_step(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] r;
    r = c ^ d;
    for (int i = 0; i < 32; i++) begin
      r = r[31] ? ((r << 1) ^ GENERATOR_POLYNOMIAL) : (r << 1);
    end
    return r;
  endfunction

  always_comb begin
    next_st = st;
    if (i_init) begin
      next_st.checksum_data_register = INIT;
    end else if (i_wr) begin
      next_st.checksum_data_register = dcf_step(st.checksum_data_register, i_wdata);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '{checksum_data_register: dcf_pkg::INIT_VALUE};
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata = st.checksum_data_register;

  chk_write_accumulates: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_wr && !i_init |=> o_rdata == dcf_step($past(o_rdata), $past(i_wdata)))
    else $error("checksum did not accumulate");
  chk_hold_idle: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    !i_wr && !i_init |=> $stable(o_rdata))
    else $error("checksum changed without write");
endmodule

/* File: rtl/dcf_feeder.sv */
// dma channel streaming a memory buffer into the checksum unit
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ns
module dcf_feeder #(
  parameter int unsigned CNT_W = dcf_pkg::CNT_W
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // register port
  input wire logic [3:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // memory read port, data taken in the request cycle
  output logic o_mem_rd,
  output logic [31:0] o_mem_addr,
  input wire logic [31:0] i_mem_rdata,
  // interrupt
  output logic o_irq
);
  typedef enum logic [2:0] {
    DCF_IDLE = 3'b001,
    DCF_REQ = 3'b010,
    DCF_WAIT = 3'b100
  } dcf_fsm_t;

  typedef struct packed {
    dcf_fsm_t fsm;
    logic [dcf_pkg::CTRL_W-1:0] ctrl;
    logic [31:0] src;
    logic [31:0] cur;
    logic [CNT_W-1:0] len;
    logic [CNT_W-1:0] cnt;
    logic tc;
    logic mask;
    logic mem_rd;
    logic irq;
    logic [31:0] rdata;
  } dcf_state_t;

  dcf_state_t st, next_st;
  logic cu_wr;
  logic cu_init;
  logic [31:0] cu_wdata;
  logic [31:0] cu_rdata;
  logic [1:0] size;
  logic [31:0] inc;
  logic [31:0] lane;
  logic wr_stat;

  assign size = st.ctrl[dcf_pkg::CTRL_SIZE_LO +: 2];
  assign wr_stat = i_reg_wr && i_reg_addr == dcf_pkg::OFS_STAT;

  always_comb begin
    unique case (size)
      dcf_pkg::SIZE_BYTE: inc = 32'h00000001;
      dcf_pkg::SIZE_HALF: inc = 32'h00000002;
      default: inc = 32'h00000004;
    endcase
  end

  // pick the element out of the word by the low address bits
  always_comb begin
    lane = i_mem_rdata >> {st.cur[1:0], 3'h0};
    unique case (size)
      dcf_pkg::SIZE_BYTE: cu_wdata = {24'h000000, lane[7:0]};
      dcf_pkg::SIZE_HALF: cu_wdata = {16'h0000, lane[15:0]};
      default: cu_wdata = i_mem_rdata;
    endcase
  end

  // each read beat writes one element to the fixed checksum register
  assign cu_wr = st.fsm == DCF_WAIT;
  assign cu_init = i_reg_wr && i_reg_addr == dcf_pkg::OFS_CTRL && i_reg_wdata[dcf_pkg::CTRL_EN]
                   && !st.ctrl[dcf_pkg::CTRL_EN];

  dcf_checksum_unit u_cu (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_init(cu_init),
    .i_wr(cu_wr),
    .i_wdata(cu_wdata),
    .o_rdata(cu_rdata)
  );

  always_comb begin
    next_st = st;
    next_st.mem_rd = 1'b0;
    next_st.rdata = 32'h00000000;
    // register writes
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        dcf_pkg::OFS_CTRL: begin
          next_st.ctrl = i_reg_wdata[dcf_pkg::CTRL_W-1:0];
          next_st.mask = i_reg_wdata[dcf_pkg::CTRL_TCIE];
        end
        dcf_pkg::OFS_SRC: next_st.src = i_reg_wdata;
        dcf_pkg::OFS_LEN: next_st.len = i_reg_wdata[CNT_W-1:0];
        default: ;
      endcase
    end
    // write one to clear; a same-cycle completion below wins
    if (wr_stat && i_reg_wdata[dcf_pkg::STAT_TC]) begin
      next_st.tc = 1'b0;
    end
    unique case (st.fsm)
      DCF_IDLE: begin
        // enable rising with a nonzero length starts a run; a stale enable never restarts it
        if (cu_init && st.len != '0) begin
          next_st.cur = st.src;
          next_st.cnt = st.len;
          next_st.fsm = DCF_REQ;
        end
      end
      DCF_REQ: begin
        // single beats; fifo bit is ignored so timing is identical
        next_st.mem_rd = 1'b1;
        next_st.fsm = DCF_WAIT;
      end
      DCF_WAIT: begin
        next_st.cur = st.cur + inc;
        next_st.cnt = st.cnt - 1'b1;
        if (st.cnt == 1) begin
          next_st.tc = 1'b1;
          next_st.fsm = DCF_IDLE;
          if (st.ctrl[dcf_pkg::CTRL_STREAM]) begin
            next_st.ctrl[dcf_pkg::CTRL_EN] = 1'b0;
          end
        end else begin
          next_st.fsm = DCF_REQ;
        end
      end
      default: next_st.fsm = DCF_IDLE;
    endcase
    next_st.mask = next_st.ctrl[dcf_pkg::CTRL_TCIE];
    next_st.irq = next_st.tc && next_st.mask;
    // register reads
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        dcf_pkg::OFS_CTRL: next_st.rdata = {26'h0000000, st.ctrl};
        dcf_pkg::OFS_SRC: next_st.rdata = st.src;
        dcf_pkg::OFS_LEN: next_st.rdata = 32'(st.cnt);
        dcf_pkg::OFS_STAT: next_st.rdata = {30'h00000000, st.fsm != DCF_IDLE, st.tc};
        default: next_st.rdata = cu_rdata; // checksum result at any other offset
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '{fsm: DCF_IDLE, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign o_reg_rdata = st.rdata;
  assign o_mem_rd = st.mem_rd;
  assign o_mem_addr = st.cur;
  assign o_irq = st.irq;

  // checks on the channel's own behaviour, in terms of its programmed state
  chk_irq_follows_flag: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_irq == (st.tc && st.ctrl[dcf_pkg::CTRL_TCIE]))
    else $error("irq does not follow flag and enable");
  chk_start_loads: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    st.fsm == DCF_IDLE && cu_init && st.len != '0 |=> st.fsm == DCF_REQ && st.cnt == $past(st.len) && o_mem_addr == $past(st.src))
    else $error("start did not load counter and source");
  chk_no_restart: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    st.fsm == DCF_IDLE && i_reg_wr && i_reg_addr == dcf_pkg::OFS_CTRL && st.ctrl[dcf_pkg::CTRL_EN] |=> st.fsm == DCF_IDLE)
    else $error("channel restarted with enable still set");
  chk_tc_held: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    st.tc && !(wr_stat && i_reg_wdata[dcf_pkg::STAT_TC]) |=> st.tc)
    else $error("complete flag dropped without clear");
  chk_count_down: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    st.fsm == DCF_WAIT |=> st.cnt == $past(st.cnt) - 1'b1)
    else $error("counter did not step");
  chk_tc_at_end: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    st.fsm == DCF_WAIT && st.cnt == 1 |=> st.tc && st.fsm == DCF_IDLE)
    else $error("no completion at last element");
  chk_stream_disable: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    st.fsm == DCF_WAIT && st.cnt == 1 && st.ctrl[dcf_pkg::CTRL_STREAM] && !i_reg_wr
    |=> !st.ctrl[dcf_pkg::CTRL_EN])
    else $error("stream enable not cleared");
  chk_src_advance: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    st.fsm == DCF_WAIT |=> o_mem_addr == $past(o_mem_addr) + $past(inc))
    else $error("source did not advance by size");
  chk_beat_timing: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    st.fsm == DCF_REQ |=> o_mem_rd ##1 (!o_mem_rd))
    else $error("beat is not single");
  chk_size_lane: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    cu_wr && size == dcf_pkg::SIZE_BYTE |-> cu_wdata[31:8] == 24'h000000)
    else $error("byte element not masked");
  chk_addr_hold: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    st.fsm == DCF_REQ |=> $stable(o_mem_addr))
    else $error("source moved before its beat");
  // read data must not linger, software may sample late
  chk_rdata_idle: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    !i_reg_rd |=> o_reg_rdata == 32'h00000000)
    else $error("read data stands without read");

  cov_stream_run: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
    st.fsm == DCF_WAIT && st.cnt == 1 && st.ctrl[dcf_pkg::CTRL_STREAM]);
  cov_irq: cover property (@(posedge i_sys_clk) disable iff (!i_resetn) $rose(o_irq));
  cov_set_clear: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
    st.fsm == DCF_WAIT && st.cnt == 1 && wr_stat && i_reg_wdata[dcf_pkg::STAT_TC]);
  cov_refused_start: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
    st.fsm == DCF_IDLE && cu_init == 1'b0 && i_reg_wr && i_reg_addr == dcf_pkg::OFS_CTRL && st.ctrl[dcf_pkg::CTRL_EN]);
  cov_half_run: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
    cu_wr && size == dcf_pkg::SIZE_HALF);
endmodule

/* File: tb/dcf_mem_model.sv */
// memory model serving element reads for the checksum feeder
`timescale 1ns/1ns
module dcf_mem_model (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // read port
  input wire logic i_rd,
  input wire logic [31:0] i_addr,
  output logic [31:0] o_rdata
);
  logic [7:0] b;
  logic [31:0] word;
  assign b = {i_addr[7:2], 2'h0};
  assign word = {b ^ 8'h3c, ~b, b + 8'h07, b};
  // the feeder takes the element in the cycle of its request, so answer then;
  // inverted otherwise so stale data never looks valid
  assign o_rdata = !i_resetn ? 32'h0 : (i_rd ? word : ~word);
endmodule

/* File: tb/dcf_feeder_bench.sv */
// self-checking bench for the dma checksum feeder
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin \
  $display("MISMATCH %s exp %h got %h", nm, ex, got); errors++; end end
module dcf_feeder_bench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, mrdata, maddr, rv, exp_addr, step, exp_crc;
  logic mrd, irq;
  int errors = 0;
  int total_checks = 0;
  int n_rd = 0;
  int cyc = 0;
  int first_rd = 0;
  int last_rd = 0;
  int d0, d1;
  initial forever #10 clk = ~clk;
  dcf_feeder i_dcf_feeder (.i_sys_clk(clk), .i_resetn(rstn), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_mem_rd(mrd), .o_mem_addr(maddr),
    .i_mem_rdata(mrdata), .o_irq(irq));
  dcf_mem_model i_dcf_mem_model (.i_sys_clk(clk), .i_resetn(rstn), .i_rd(mrd), .i_addr(maddr), .o_rdata(mrdata));
  // each element request must hit the next source address
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (mrd) begin
      `CHK("mem_addr", exp_addr, maddr)
      exp_addr <= exp_addr + step;
      n_rd <= n_rd + 1;
      if (n_rd == 0) first_rd <= cyc;
      last_rd <= cyc;
    end
  end
  function automatic logic [31:0] crc(input logic [31:0] c, input logic [31:0] d);
    c = c ^ d;
    for (int i = 0; i < 32; i++) c = c[31] ? (c << 1) ^ dcf_pkg::GEN_GENERATOR_POLYNOMIAL : c << 1;
    return c;
  endfunction
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic xfer(input logic [1:0] sz, input logic [31:0] src, input int len, input logic strm,
    input logic fifo, input logic tcie, output int dur);
    logic [31:0] w, a;
    logic [7:0] b;
    exp_crc = dcf_pkg::INIT_VALUE;
    step = 32'h1 << sz;
    exp_addr = src;
    n_rd = 0;
    wreg(dcf_pkg::OFS_SRC, src);
    wreg(dcf_pkg::OFS_LEN, len);
    wreg(dcf_pkg::OFS_CTRL, {26'h0, fifo, sz, strm, tcie, 1'b1});
    for (int i = 0; i < 200 && n_rd < len; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    `CHK("elements", len, n_rd)
    dur = last_rd - first_rd;
    `CHK("spacing", 2 * (len - 1), dur)
    rreg(dcf_pkg::OFS_LEN, rv);
    `CHK("len_left", 32'h0, rv)
    rreg(dcf_pkg::OFS_STAT, rv);
    `CHK("status", 32'h1, rv)
    `CHK("irq", tcie, irq)
    rreg(dcf_pkg::OFS_CTRL, rv);
    `CHK("enable", ~strm, rv[0])
    for (int i = 0; i < len; i++) begin
      a = src + i * step;
      b = {a[7:2], 2'h0};
      w = {b ^ 8'h3c, ~b, b + 8'h07, b} >> (8 * a[1:0]);
      if (sz == dcf_pkg::SIZE_BYTE) w = w & 32'hff;
      else if (sz == dcf_pkg::SIZE_HALF) w = w & 32'hffff;
      exp_crc = crc(exp_crc, w);
    end
    rreg(4'h1, rv);
    `CHK("checksum", exp_crc, rv)
  endtask
  task automatic end_sim();
    if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    end_sim();
  end
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rreg(4'h1, rv);
    `CHK("checksum_rst", dcf_pkg::INIT_VALUE, rv)
    rreg(dcf_pkg::OFS_CTRL, rv);
    `CHK("ctrl_rst", 32'h0, rv)
    xfer(dcf_pkg::SIZE_BYTE, 32'h101, 5, 1'b1, 1'b0, 1'b1, d0);
    repeat (10) @(posedge clk);
    `CHK("irq_held", 1'b1, irq)
    wreg(dcf_pkg::OFS_STAT, 32'h1);
    rreg(dcf_pkg::OFS_STAT, rv);
    `CHK("status_clr", 32'h0, rv)
    `CHK("irq_clr", 1'b0, irq)
    xfer(dcf_pkg::SIZE_HALF, 32'h202, 4, 1'b0, 1'b1, 1'b0, d0);
    // enable left set by channel variant, so a new start is refused
    n_rd = 0;
    wreg(dcf_pkg::OFS_CTRL, 32'h9);
    repeat (12) @(posedge clk);
    `CHK("no_restart", 0, n_rd)
    wreg(dcf_pkg::OFS_CTRL, 32'h2);
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK("irq_unmask", 1'b1, irq)
    wreg(dcf_pkg::OFS_STAT, 32'h1);
    xfer(dcf_pkg::SIZE_WORD, 32'h300, 6, 1'b1, 1'b0, 1'b1, d0);
    wreg(dcf_pkg::OFS_STAT, 32'h1);
    xfer(dcf_pkg::SIZE_WORD, 32'h300, 6, 1'b1, 1'b1, 1'b1, d1);
    `CHK("fifo_time", d0, d1)
    wreg(4'h1, 32'h0);
    rreg(4'h1, rv);
    `CHK("unmapped_wr", exp_crc, rv)
    end_sim();
  end
endmodule
